// ===== common/pmsr_pkg.sv
// ****************************************
// Package for the modem status register bank
// ****************************************
package pmsr_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_BUFFER_POINTER = 8'h0d;
    localparam logic [7:0] ADDR_TX_BUFFER_BASE = 8'h0e;
    localparam logic [7:0] ADDR_RX_BUFFER_BASE = 8'h0f;
    localparam logic [7:0] ADDR_LAST_RX_START = 8'h10;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'h11;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h12;
    localparam logic [7:0] ADDR_RX_PAYLOAD_LEN = 8'h13;
    localparam logic [7:0] ADDR_HDR_CNT_HIGH = 8'h14;
    localparam logic [7:0] ADDR_HDR_CNT_LOW = 8'h15;
    localparam logic [7:0] ADDR_PKT_CNT_HIGH = 8'h16;
    localparam logic [7:0] ADDR_PKT_CNT_LOW = 8'h17;
    localparam logic [7:0] ADDR_MODEM_STATE = 8'h18;
    localparam logic [7:0] ADDR_PACKET_SNR = 8'h19;
    // Reset values
    localparam logic [7:0] RST_TX_BUFFER_BASE = 8'h80;
    localparam logic [7:0] RST_RX_BUFFER_BASE = 8'h00;
    localparam logic [7:0] RST_BUFFER_POINTER = 8'h00;
    localparam logic [7:0] RST_EVENT_MASK = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
    localparam logic [4:0] RST_MODEM_STATE_BITS = 5'h10;
    localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
    // Flag bit positions
    localparam int BIT_RX_TIMEOUT = 7;
    localparam int BIT_RX_COMPLETE = 6;
    localparam int BIT_PAYLOAD_CHECK_FAIL = 5;
    localparam int BIT_GOOD_HEADER = 4;
    localparam int BIT_TX_COMPLETE = 3;
    localparam int BIT_DETECT_FINISHED = 2;
    localparam int BIT_HOP_CHANGE = 1;
    localparam int BIT_SIGNAL_FOUND = 0;
    // Modem status field positions
    localparam int POS_CODE_RATE = 5;
    localparam int POS_MODEM_CLEAR = 4;
    // Counter step
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : pmsr_pkg

// ===== common/pmsr_cnt_if.sv
`timescale 1ns/10ps
// ****************************************
// Counter control and value carrier
// ****************************************
interface pmsr_cnt_if;
    logic clear; // Synchronous clear
    logic step; // Count one event
    logic [15:0] value; // Present count
    modport owner (input clear, input step, output value);
    modport user (output clear, output step, input value);
endinterface : pmsr_cnt_if

// ===== logic/pmsr_event_counter.sv
`timescale 1ns/10ps
// ****************************************
// Sixteen bit event counter, clear wins
// ****************************************
module pmsr_event_counter (
    input wire logic CLK,
    input wire logic RESETN,
    pmsr_cnt_if.owner cnt
);
    import pmsr_pkg::*;
    logic [15:0] count_q; // Count register
    logic [15:0] count_d; // Next count
    // Clear has priority over step
    assign count_d = cnt.clear ? CNT_ZERO : (cnt.step ? count_q + CNT_STEP : count_q);
    assign cnt.value = count_q;
    // Count register
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            count_q <= CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end
endmodule : pmsr_event_counter

// ===== logic/pmsr_regs.sv
`timescale 1ns/10ps
module pmsr_regs (
    input wire logic CLK,
    input wire logic RESETN,
    // Host register port, same clock domain
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Events from the modem datapath, one-cycle pulses
    input wire logic [7:0] EVENT_PULSES,
    input wire logic DETECT_ACTIVE,
    input wire logic SIGNAL_FOUND,
    // Packet results from the modem datapath
    input wire logic PACKET_RESULT_LOAD,
    input wire logic [7:0] LAST_RX_PACKET_START,
    input wire logic [7:0] RX_PAYLOAD_LENGTH,
    input wire logic [7:0] PACKET_SNR_QUARTER_DB,
    input wire logic HEADER_RESULT_LOAD,
    input wire logic [2:0] LAST_HEADER_CODE_RATE,
    input wire logic [3:0] MODEM_STATE_BITS,
    input wire logic MODEM_BUSY,
    input wire logic SLEEP_MODE,
    input wire logic RX_MODE_ENTRY,
    // Register contents toward the datapath
    output logic [7:0] TX_BUFFER_BASE,
    output logic [7:0] RX_BUFFER_BASE,
    output logic [7:0] BUFFER_ACCESS_POINTER,
    output logic IRQ_OUT
);
    import pmsr_pkg::*;

    // ****************************************
    // Decode
    // ****************************************
    wire sel_ptr = REG_ADDR == ADDR_BUFFER_POINTER; // Pointer select
    wire sel_tx = REG_ADDR == ADDR_TX_BUFFER_BASE; // Tx base select
    wire sel_rx = REG_ADDR == ADDR_RX_BUFFER_BASE; // Rx base select
    wire sel_mask = REG_ADDR == ADDR_EVENT_MASK; // Mask select
    wire sel_flags = REG_ADDR == ADDR_EVENT_FLAGS; // Flags select
    wire wr_ptr = REG_WRITE && sel_ptr; // Pointer write
    wire wr_tx = REG_WRITE && sel_tx; // Tx base write
    wire wr_rx = REG_WRITE && sel_rx; // Rx base write
    wire wr_mask = REG_WRITE && sel_mask; // Mask write
    wire wr_flags = REG_WRITE && sel_flags; // Flag clear write

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] tx_buffer_base_q; // Transmit base
    logic [7:0] rx_buffer_base_q; // Receive base
    logic [7:0] buffer_access_pointer_q; // Buffer pointer
    logic [7:0] event_mask_q; // Interrupt gates
    logic [7:0] event_flags_q; // Sticky flags
    logic [7:0] event_flags_d; // Next flags
    logic [7:0] event_set; // Hardware set terms
    logic [7:0] last_rx_packet_start_q; // Last packet start
    logic [7:0] rx_payload_length_q; // Payload length
    logic [7:0] packet_snr_q; // Packet SNR
    logic [2:0] code_rate_q; // Last header code rate
    logic [4:0] modem_state_bits_q; // Live status bits
    logic [7:0] rdata_q; // Read data
    logic rvalid_q; // Read answer strobe
    logic irq_q; // Interrupt output
    logic [7:0] rdata_d; // Read mux
    pmsr_cnt_if hdr_cnt (); // Header counter link
    pmsr_cnt_if pkt_cnt (); // Packet counter link

    // Signal found raised while detection runs, or directly by EVENT_PULSES bit 0
    assign event_set = {EVENT_PULSES[7:1],
        EVENT_PULSES[BIT_SIGNAL_FOUND] | (DETECT_ACTIVE & SIGNAL_FOUND)};
    // Set wins over a simultaneous host clear
    assign event_flags_d = (wr_flags ? (event_flags_q & ~REG_WDATA) : event_flags_q) | event_set;

    // ****************************************
    // Counters
    // ****************************************
    assign hdr_cnt.clear = SLEEP_MODE | RX_MODE_ENTRY;
    assign pkt_cnt.clear = SLEEP_MODE | RX_MODE_ENTRY;
    assign hdr_cnt.step = EVENT_PULSES[BIT_GOOD_HEADER];
    assign pkt_cnt.step = EVENT_PULSES[BIT_RX_COMPLETE] & ~EVENT_PULSES[BIT_PAYLOAD_CHECK_FAIL];

    // Header counter
    pmsr_event_counter u_hdr_cnt (
        .CLK(CLK),
        .RESETN(RESETN),
        .cnt(hdr_cnt)
    );
    // Packet counter
    pmsr_event_counter u_pkt_cnt (
        .CLK(CLK),
        .RESETN(RESETN),
        .cnt(pkt_cnt)
    );

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rdata_d = RST_ZERO_BYTE;
        unique case (REG_ADDR)
            ADDR_BUFFER_POINTER: rdata_d = buffer_access_pointer_q;
            ADDR_TX_BUFFER_BASE: rdata_d = tx_buffer_base_q;
            ADDR_RX_BUFFER_BASE: rdata_d = rx_buffer_base_q;
            ADDR_LAST_RX_START: rdata_d = last_rx_packet_start_q;
            ADDR_EVENT_MASK: rdata_d = event_mask_q;
            ADDR_EVENT_FLAGS: rdata_d = event_flags_q;
            ADDR_RX_PAYLOAD_LEN: rdata_d = rx_payload_length_q;
            ADDR_HDR_CNT_HIGH: rdata_d = hdr_cnt.value[15:8];
            ADDR_HDR_CNT_LOW: rdata_d = hdr_cnt.value[7:0];
            ADDR_PKT_CNT_HIGH: rdata_d = pkt_cnt.value[15:8];
            ADDR_PKT_CNT_LOW: rdata_d = pkt_cnt.value[7:0];
            ADDR_MODEM_STATE: rdata_d = {code_rate_q, modem_state_bits_q};
            ADDR_PACKET_SNR: rdata_d = packet_snr_q;
            default: rdata_d = RST_ZERO_BYTE; // Unmapped reads zero
        endcase
    end

    // ****************************************
    // Host writable registers
    // ****************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_buffer_base_q <= RST_TX_BUFFER_BASE;
            rx_buffer_base_q <= RST_RX_BUFFER_BASE;
            buffer_access_pointer_q <= RST_BUFFER_POINTER;
            event_mask_q <= RST_EVENT_MASK;
        end else begin
            if (wr_tx) begin
                tx_buffer_base_q <= REG_WDATA;
            end
            if (wr_rx) begin
                rx_buffer_base_q <= REG_WDATA;
            end
            if (wr_ptr) begin
                buffer_access_pointer_q <= REG_WDATA;
            end
            if (wr_mask) begin
                event_mask_q <= REG_WDATA;
            end
        end
    end

    // ****************************************
    // Flags and interrupt
    // ****************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            event_flags_q <= RST_EVENT_FLAGS;
            irq_q <= 1'b0;
        end else begin
            event_flags_q <= event_flags_d;
            // Masked bits never reach the interrupt
            irq_q <= |(event_flags_d & ~event_mask_q);
        end
    end

    // ****************************************
    // Packet results and status
    // ****************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            last_rx_packet_start_q <= RST_ZERO_BYTE;
            rx_payload_length_q <= RST_ZERO_BYTE;
            packet_snr_q <= RST_ZERO_BYTE;
            code_rate_q <= 3'h0;
            modem_state_bits_q <= RST_MODEM_STATE_BITS;
        end else begin
            if (PACKET_RESULT_LOAD) begin
                last_rx_packet_start_q <= LAST_RX_PACKET_START;
                rx_payload_length_q <= RX_PAYLOAD_LENGTH;
                packet_snr_q <= PACKET_SNR_QUARTER_DB;
            end
            if (HEADER_RESULT_LOAD) begin
                code_rate_q <= LAST_HEADER_CODE_RATE;
            end
            // Modem clear is the inverse of busy
            modem_state_bits_q <= {~MODEM_BUSY, MODEM_STATE_BITS};
        end
    end

    // ****************************************
    // Read answer
    // ****************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= RST_ZERO_BYTE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_READ;
            if (REG_READ) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Every output comes straight from a register
    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign TX_BUFFER_BASE = tx_buffer_base_q;
    assign RX_BUFFER_BASE = rx_buffer_base_q;
    assign BUFFER_ACCESS_POINTER = buffer_access_pointer_q;
    assign IRQ_OUT = irq_q;

    // ****************************************
    // Checks: reset values
    // ****************************************
    // Register values seen at the first edge after release
    chk_tx_base_reset: assert property (@(posedge CLK)
        $rose(RESETN) |-> tx_buffer_base_q == 8'h80)
        else $error("tx base not 0x80 after reset");
    chk_base_resets: assert property (@(posedge CLK)
        $rose(RESETN) |-> rx_buffer_base_q == 8'h00 && event_mask_q == 8'h00 && buffer_access_pointer_q == 8'h00)
        else $error("base, mask or pointer wrong after reset");
    chk_flags_reset: assert property (@(posedge CLK)
        $rose(RESETN) |-> event_flags_q == 8'h00 && modem_state_bits_q == 5'h10)
        else $error("flags or status wrong after reset");

    // ****************************************
    // Checks: host writes
    // ****************************************
    // Written value lands at the next edge
    chk_rx_base_write: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_rx |=> rx_buffer_base_q == $past(REG_WDATA))
        else $error("rx base write lost");
    chk_tx_base_write: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_tx |=> TX_BUFFER_BASE == $past(REG_WDATA))
        else $error("tx base write lost");
    chk_pointer_write: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ptr |=> BUFFER_ACCESS_POINTER == $past(REG_WDATA))
        else $error("pointer write lost");
    chk_mask_write: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_mask |=> event_mask_q == $past(REG_WDATA))
        else $error("mask write lost");
    // A write to a read-only place changes nothing
    sequence s_ro_write;
        REG_WRITE && (REG_ADDR == ADDR_RX_PAYLOAD_LEN) && !PACKET_RESULT_LOAD;
    endsequence
    chk_ro_write_ignored: assert property (@(posedge CLK) disable iff (!RESETN)
        s_ro_write |=> rx_payload_length_q == $past(rx_payload_length_q))
        else $error("read-only register took a write");

    // ****************************************
    // Checks: flags and interrupt
    // ****************************************
    // Host clear with no event in the same cycle
    sequence s_clear_write;
        REG_WRITE && sel_flags && (EVENT_PULSES == 8'h00) && !(DETECT_ACTIVE && SIGNAL_FOUND);
    endsequence
    sequence s_flags_gone;
        ##1 ((event_flags_q & $past(REG_WDATA)) == 8'h00);
    endsequence
    chk_flag_clear_write: assert property (@(posedge CLK) disable iff (!RESETN)
        s_clear_write |-> s_flags_gone)
        else $error("flag write did not clear");
    // Without a host write no flag ever drops
    chk_flags_sticky: assert property (@(posedge CLK) disable iff (!RESETN)
        !wr_flags |=> (event_flags_q & $past(event_flags_q)) == $past(event_flags_q))
        else $error("flag dropped without a write");
    chk_flag_set_wins: assert property (@(posedge CLK) disable iff (!RESETN)
        EVENT_PULSES[BIT_RX_TIMEOUT] |=> event_flags_q[BIT_RX_TIMEOUT])
        else $error("event flag not set");
    chk_signal_found: assert property (@(posedge CLK) disable iff (!RESETN)
        (DETECT_ACTIVE && SIGNAL_FOUND) |=> event_flags_q[BIT_SIGNAL_FOUND])
        else $error("signal found flag missing");
    chk_mask_gates_irq: assert property (@(posedge CLK) disable iff (!RESETN)
        ((event_flags_q & ~event_mask_q) == 8'h00) && (event_set == 8'h00) && !$changed(event_mask_q)
        |=> !IRQ_OUT)
        else $error("masked flag raised interrupt");
    // An unmasked standing flag keeps the interrupt up
    chk_unmasked_irq: assert property (@(posedge CLK) disable iff (!RESETN)
        event_flags_q[BIT_RX_TIMEOUT] && !event_mask_q[BIT_RX_TIMEOUT] && !wr_flags |=> IRQ_OUT)
        else $error("unmasked flag gave no interrupt");

    // ****************************************
    // Checks: counters and results
    // ****************************************
    chk_sleep_clears: assert property (@(posedge CLK) disable iff (!RESETN)
        SLEEP_MODE |=> hdr_cnt.value == 16'h0000 && pkt_cnt.value == 16'h0000)
        else $error("counters not cleared in sleep");
    chk_entry_clears: assert property (@(posedge CLK) disable iff (!RESETN)
        RX_MODE_ENTRY |=> hdr_cnt.value == 16'h0000 && pkt_cnt.value == 16'h0000)
        else $error("counters not cleared on rx entry");
    chk_header_count: assert property (@(posedge CLK) disable iff (!RESETN)
        hdr_cnt.step && !hdr_cnt.clear |=> hdr_cnt.value == $past(hdr_cnt.value) + 16'h0001)
        else $error("header count missed step");
    chk_packet_count: assert property (@(posedge CLK) disable iff (!RESETN)
        pkt_cnt.step && !pkt_cnt.clear |=> pkt_cnt.value == $past(pkt_cnt.value) + 16'h0001)
        else $error("packet count missed step");
    // A packet with a failed payload check is not counted
    sequence s_failed_packet;
        EVENT_PULSES[BIT_RX_COMPLETE] && EVENT_PULSES[BIT_PAYLOAD_CHECK_FAIL] && !pkt_cnt.clear;
    endsequence
    chk_failed_packet: assert property (@(posedge CLK) disable iff (!RESETN)
        s_failed_packet |=> pkt_cnt.value == $past(pkt_cnt.value))
        else $error("failed packet was counted");
    chk_status_read: assert property (@(posedge CLK) disable iff (!RESETN)
        REG_READ && REG_ADDR == ADDR_MODEM_STATE |=> REG_RDATA[4] == !$past(MODEM_BUSY, 2) && REG_RVALID)
        else $error("status read wrong");
    chk_code_rate_load: assert property (@(posedge CLK) disable iff (!RESETN)
        HEADER_RESULT_LOAD |=> code_rate_q == $past(LAST_HEADER_CODE_RATE))
        else $error("code rate not loaded");
    chk_snr_load: assert property (@(posedge CLK) disable iff (!RESETN)
        PACKET_RESULT_LOAD |=> packet_snr_q == $past(PACKET_SNR_QUARTER_DB)
        && rx_payload_length_q == $past(RX_PAYLOAD_LENGTH))
        else $error("packet results not loaded");
    chk_start_load: assert property (@(posedge CLK) disable iff (!RESETN)
        PACKET_RESULT_LOAD |=> last_rx_packet_start_q == $past(LAST_RX_PACKET_START))
        else $error("packet start not loaded");
endmodule : pmsr_regs

// ===== sim/pmsr_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host side of the register port
// ****************************************
module pmsr_host_model (
    input wire logic CLK,
    output logic [7:0] REG_ADDR,
    output logic REG_WRITE,
    output logic REG_READ,
    output logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID
);
    import pmsr_pkg::*;
    // Quiet port at time zero
    initial begin
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WRITE = 1'b0;
        REG_READ = 1'b0;
    end
    // One write cycle; released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        #1;
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WRITE = 1'b1;
        @(posedge CLK);
        #1;
        REG_WRITE = 1'b0;
        REG_ADDR = ~a;
        REG_WDATA = ~d;
    endtask : wr
    // Acknowledge serviced events by a flag write
    task automatic ack(input logic [7:0] bits);
        wr(ADDR_EVENT_FLAGS, bits);
    endtask : ack
    // One read; data taken while the valid pulse stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        #1;
        REG_ADDR = a;
        REG_READ = 1'b1;
        @(posedge CLK);
        #1;
        REG_READ = 1'b0;
        REG_ADDR = ~a;
        d = (REG_RVALID === 1'b1) ? REG_RDATA : 8'hxx;
    endtask : rd
endmodule : pmsr_host_model

// ===== sim/test_packet_modem_status_irq_regs.sv
`timescale 1ns/10ps
// ****************************************
// Register bank self-checking bench
// ****************************************
module test_packet_modem_status_irq_regs;
    import pmsr_pkg::*;
    logic clk = 1'b0; // Bench clock
    logic resetn = 1'b0; // Reset, active low
    logic [7:0] addr, wdata, rdata, ev, rxs, len, snr, txb, rxb, ptr; // Port nets
    logic wr_en, rd_en, rvalid, irq, det, found, pload, hload, busy, sleep, entry; // Strobes
    logic [2:0] rate = 3'h0; // Header code rate
    logic [3:0] st = 4'h0; // Live state bits
    logic [7:0] acc; // Expected flag image
    int fail_count = 0; // Mismatches
    int comparisons = 0; // Compares made
    // Half period inverter
    always #5 clk = ~clk;
    // Design under test
    pmsr_regs pmsr_regs_inst (.CLK(clk), .RESETN(resetn), .REG_ADDR(addr), .REG_WRITE(wr_en),
        .REG_READ(rd_en), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .EVENT_PULSES(ev), .DETECT_ACTIVE(det), .SIGNAL_FOUND(found), .PACKET_RESULT_LOAD(pload),
        .LAST_RX_PACKET_START(rxs), .RX_PAYLOAD_LENGTH(len), .PACKET_SNR_QUARTER_DB(snr),
        .HEADER_RESULT_LOAD(hload), .LAST_HEADER_CODE_RATE(rate), .MODEM_STATE_BITS(st),
        .MODEM_BUSY(busy), .SLEEP_MODE(sleep), .RX_MODE_ENTRY(entry), .TX_BUFFER_BASE(txb),
        .RX_BUFFER_BASE(rxb), .BUFFER_ACCESS_POINTER(ptr), .IRQ_OUT(irq));
    // Host partner on the register port
    pmsr_host_model pmsr_host_model_inst (.CLK(clk), .REG_ADDR(addr), .REG_WRITE(wr_en),
        .REG_READ(rd_en), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Read one register and compare
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        pmsr_host_model_inst.rd(a, d);
        check(d, exp);
    endtask : rc
    // One-cycle event pulse
    task automatic pulse(input logic [7:0] bits);
        @(posedge clk);
        #1;
        ev = bits;
        @(posedge clk);
        #1;
        ev = 8'h00;
    endtask : pulse
    // Verdict and end of run
    task automatic complete_run;
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // Watchdog against a hang
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        {ev, det, found, pload, hload, busy, sleep, entry} = '0;
        {rxs, len, snr} = '0;
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        // Reset values
        rc(ADDR_TX_BUFFER_BASE, 8'h80);
        rc(ADDR_RX_BUFFER_BASE, 8'h00);
        rc(ADDR_EVENT_MASK, 8'h00);
        rc(ADDR_EVENT_FLAGS, 8'h00);
        rc(ADDR_MODEM_STATE, 8'h10);
        rc(ADDR_BUFFER_POINTER, 8'h00);
        // Read/write places, read-only and unmapped
        pmsr_host_model_inst.wr(ADDR_TX_BUFFER_BASE, 8'h5a);
        pmsr_host_model_inst.wr(ADDR_RX_BUFFER_BASE, 8'ha5);
        pmsr_host_model_inst.wr(ADDR_BUFFER_POINTER, 8'hc3);
        pmsr_host_model_inst.wr(ADDR_RX_PAYLOAD_LEN, 8'h55);
        check(txb, 8'h5a);
        check(rxb, 8'ha5);
        check(ptr, 8'hc3);
        rc(ADDR_TX_BUFFER_BASE, 8'h5a);
        rc(ADDR_RX_BUFFER_BASE, 8'ha5);
        rc(ADDR_RX_PAYLOAD_LEN, 8'h00);
        rc(8'h20, 8'h00);
        // Every event with all gates set
        pmsr_host_model_inst.wr(ADDR_EVENT_MASK, 8'hff);
        acc = 8'h00;
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            acc = acc | (8'h01 << i);
            rc(ADDR_EVENT_FLAGS, acc);
            check({7'h00, irq}, 8'h00);
        end
        pmsr_host_model_inst.ack(8'h0f);
        rc(ADDR_EVENT_FLAGS, 8'hf0);
        pmsr_host_model_inst.wr(ADDR_EVENT_MASK, 8'h7f);
        @(posedge clk);
        #1;
        check({7'h00, irq}, 8'h01);
        pmsr_host_model_inst.ack(8'hff);
        rc(ADDR_EVENT_FLAGS, 8'h00);
        check({7'h00, irq}, 8'h00);
        // Detection result sets the found flag
        found = 1'b1;
        @(posedge clk);
        #1;
        rc(ADDR_EVENT_FLAGS, 8'h00);
        det = 1'b1;
        @(posedge clk);
        #1;
        {det, found} = 2'b00;
        rc(ADDR_EVENT_FLAGS, 8'h01);
        // Packet and header results
        {rxs, len, snr} = {8'h3e, 8'hff, 8'hec};
        pload = 1'b1;
        {rate, st, busy} = {3'h5, 4'ha, 1'b1};
        hload = 1'b1;
        @(posedge clk);
        #1;
        {pload, hload} = 2'b00;
        {rxs, len, snr} = '0;
        rc(ADDR_LAST_RX_START, 8'h3e);
        rc(ADDR_RX_PAYLOAD_LEN, 8'hff);
        rc(ADDR_PACKET_SNR, 8'hec);
        rc(ADDR_MODEM_STATE, 8'haa);
        // Counters across the byte boundary, from a fresh rx entry
        entry = 1'b1;
        @(posedge clk);
        #1;
        entry = 1'b0;
        for (int i = 0; i < 300; i++) pulse(8'h10);
        pulse(8'h40);
        pulse(8'h60);
        pulse(8'h40);
        rc(ADDR_HDR_CNT_HIGH, 8'h01);
        rc(ADDR_HDR_CNT_LOW, 8'h2c);
        rc(ADDR_PKT_CNT_HIGH, 8'h00);
        rc(ADDR_PKT_CNT_LOW, 8'h02);
        sleep = 1'b1;
        @(posedge clk);
        #1;
        sleep = 1'b0;
        rc(ADDR_HDR_CNT_LOW, 8'h00);
        rc(ADDR_HDR_CNT_HIGH, 8'h00);
        rc(ADDR_PKT_CNT_LOW, 8'h00);
        pulse(8'h50);
        rc(ADDR_HDR_CNT_LOW, 8'h01);
        rc(ADDR_PKT_CNT_LOW, 8'h01);
        entry = 1'b1;
        @(posedge clk);
        #1;
        entry = 1'b0;
        rc(ADDR_HDR_CNT_LOW, 8'h00);
        rc(ADDR_PKT_CNT_LOW, 8'h00);
        complete_run();
    end
endmodule : test_packet_modem_status_irq_regs
